// ---- src/tcr_defs.svh ----
// constants of the thermocouple result and fault block: offsets, fields, resets, timing
// assumes it is included by bare name from the design module
`ifndef TCR_DEFS_SVH
`define TCR_DEFS_SVH
// register offsets, read address space (writes use the same index with bit 7 set)
`define TCR_ADDR_CFG0 7'h00
`define TCR_ADDR_CFG1 7'h01
`define TCR_ADDR_MASK 7'h02
`define TCR_ADDR_CJHF 7'h03
`define TCR_ADDR_CJLF 7'h04
`define TCR_ADDR_LTHFH 7'h05
`define TCR_ADDR_LTHFL 7'h06
`define TCR_ADDR_LTLFH 7'h07
`define TCR_ADDR_LTLFL 7'h08
`define TCR_ADDR_CJTO 7'h09
`define TCR_ADDR_CJTH 7'h0A
`define TCR_ADDR_CJTL 7'h0B
`define TCR_ADDR_LIN2 7'h0C
`define TCR_ADDR_LIN1 7'h0D
`define TCR_ADDR_LIN0 7'h0E
`define TCR_ADDR_FAULT 7'h0F
`define TCR_UNMAPPED_DATA 8'hFF
// reset values
`define TCR_RST_CFG0 8'h00
`define TCR_RST_CFG1 8'h03
`define TCR_RST_MASK 8'hFF
`define TCR_RST_CJHF 8'h7F
`define TCR_RST_CJLF 8'hC0
`define TCR_RST_LTHF 16'h7FFF
`define TCR_RST_LTLF 16'h8000
`define TCR_RST_CJTO 8'h00
// configuration zero fields
`define TCR_C0_CMODE 7
`define TCR_C0_ONESHOT 6
`define TCR_C0_OC_HI 5
`define TCR_C0_OC_LO 4
`define TCR_C0_CJ_OFF 3
`define TCR_C0_INT_MODE 2
`define TCR_C0_FCLR 1
// cold-junction word clamp and table origin
`define TCR_CJ_MAX 18'h07FFC
`define TCR_CJ_MIN 18'h3C000
`define TCR_CJ_BIAS 16'h4000
`define TCR_OFFSET_SHIFT 4
`define TCR_LIN_SCALE 128
`define TCR_CJ_SCALE 256
`define TCR_SENS_SHIFT 6
// open test taken once per this many continuous conversions
`define TCR_OPEN_EVERY 16
// timing: clock rate and open-test lengths (typical, in microseconds)
`define TCR_CLK_MHZ 100
`define TCR_OPEN_CJ_01_US 13300
`define TCR_OPEN_CJ_10_US 33400
`define TCR_OPEN_CJ_11_US 113400
`define TCR_OPEN_NOCJ_01_US 40000
`define TCR_OPEN_NOCJ_10_US 60000
`define TCR_OPEN_NOCJ_11_US 140000
`endif

// ---- src/tcr_pkg.sv ----
// types shared by the thermocouple result and fault block
// assumes tcr_defs.svh is on the include path
package tcr_pkg;
   typedef enum logic [2:0] {
      TCR_S_IDLE,
      TCR_S_CONV,
      TCR_S_COMP,
      TCR_S_LIN,
      TCR_S_OPEN,
      TCR_S_DONE
   } tcr_state_t;

   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic sdi;
   } tcr_spi_pins_t;

   // same bit order as the fault status register
   typedef struct packed {
      logic cj_range;
      logic tc_range;
      logic cj_high;
      logic cj_low;
      logic tc_high;
      logic tc_low;
      logic input_range_violation;
      logic open;
   } tcr_status_t;
endpackage : tcr_pkg

// ---- src/tcr_top.sv ----
// thermocouple result and fault logic: compensation, linearization, thresholds, serial port
// assumes front end on clk_in; serial pins and the input monitor are asynchronous
//
// What this block does
// [RULE1] cold-junction temperature to code by interpolated table
// [RULE2] add cold-junction code to raw conversion
// [RULE3] cold-junction word: 16-bit, bit2 is 1/64 degree
// [RULE4] store 19-bit result over three bytes, MSB first
// [RULE5] result word: 24-bit, bit8 is 1/16 degree
// [RULE6] host reads three result bytes in one burst
// [RULE7] cold-junction high/low thresholds set status and fault
// [RULE8] result high/low thresholds set status and fault
// [RULE9] result thresholds share the result encoding
// [RULE10] input over/undervoltage sets bit 1 and fault
// [RULE11] conversions pause while input violation persists
// [RULE12] open-detect field: 00 off, three window lengths
// [RULE13] single-shot runs open test every conversion
// [RULE14] continuous mode tests once every 16 conversions
// [RULE15] 00 then code requests one test after conversion
// [RULE16] disabling detection keeps open fault in comparator mode
// [RULE17] cold-junction measured during the open test
// [RULE18] open test length depends on code and sensing
// [RULE19] open circuit sets bit 0 and fault
// [RULE20] D7 cold-junction range, D6 hot-junction range
// [RULE21] clamp reported temperature at range limit
// [RULE22] range flags never drive the fault output
// [RULE23] cold-junction value clamped to -64..128 degrees
// [RULE24] cold-junction value includes signed offset register
// [RULE25] thresholds compare strictly, signed
`timescale 1ns/1ps
`include "tcr_defs.svh"

module tcr_top #(
   parameter int unsigned OPEN_CJ_01_CYC = `TCR_OPEN_CJ_01_US * `TCR_CLK_MHZ,
   parameter int unsigned OPEN_CJ_10_CYC = `TCR_OPEN_CJ_10_US * `TCR_CLK_MHZ,
   parameter int unsigned OPEN_CJ_11_CYC = `TCR_OPEN_CJ_11_US * `TCR_CLK_MHZ,
   parameter int unsigned OPEN_NOCJ_01_CYC = `TCR_OPEN_NOCJ_01_US * `TCR_CLK_MHZ,
   parameter int unsigned OPEN_NOCJ_10_CYC = `TCR_OPEN_NOCJ_10_US * `TCR_CLK_MHZ,
   parameter int unsigned OPEN_NOCJ_11_CYC = `TCR_OPEN_NOCJ_11_US * `TCR_CLK_MHZ
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sclk_in,
   input wire logic spi_sdi_in,
   output logic spi_sdo_out,
   output logic spi_sdo_oe_out,
   output logic fault_n_out,
   output logic data_ready_n_out,
   output logic adc_start_out,
   input wire logic adc_done_in,
   input wire logic [18:0] adc_code_in,
   input wire logic [13:0] cj_meas_in,
   output logic open_bias_out,
   input wire logic open_circuit_in,
   input wire logic input_range_violation_in
);
   // curve tables; the conversion curve is shared by all types, only sensitivity and range limits differ
   localparam int CJ_LUT [0:7] = '{-9300, -4600, 0, 4560, 9080, 13560, 18000, 22400};
   localparam int LIN_DEG [0:16] = '{-270, -262, -245, -220, -185, -140, -90, -45, 0,
                                     230, 460, 690, 920, 1150, 1380, 1600, 1800};
   localparam int SENS [0:7] = '{16, 118, 90, 64, 56, 16, 15, 81};
   localparam int HOT_LO [0:7] = '{250, -200, -210, -200, -200, -50, -50, -200};
   localparam int HOT_HI [0:7] = '{1820, 1000, 1200, 1372, 1300, 1768, 1768, 400};
   localparam int CJ_LO [0:7] = '{0, -55, -55, -55, -55, -50, -50, -55};
   localparam int CJ_HI = 125;

   // synchronisers for pins from outside the clock domain
   tcr_pkg::tcr_spi_pins_t pin_meta, pin_sync, pin_prev;
   logic viol_meta, viol_sync;

   // registers
   logic [7:0] cfg0, cfg1, mask, cjhf, cjlf, cjto;
   logic [15:0] lthf, ltlf, cj_word, cj_shadow;
   logic [23:0] lin_word, lin_shadow;
   tcr_pkg::tcr_status_t status;
   logic oc_zeroed, demand_req;

   // serial port state
   logic idle_pol, is_write, addr_phase;
   logic [2:0] bit_cnt;
   logic [6:0] addr;
   logic [7:0] shift_in, tx;
   logic lead_edge, trail_edge, cs_fall, byte_done, wr_en, rd_load, drdy_clr;
   logic [7:0] rx_byte, rd_data;
   logic [6:0] rd_addr;

   // conversion engine
   tcr_pkg::tcr_state_t state;
   logic [23:0] cyc_cnt;
   logic [3:0] conv_cnt;
   logic test_due, cj_load, result_upd, open_upd, open_result, conv_complete;
   logic demand_taken;
   logic [18:0] raw_code;
   logic signed [19:0] cj_code;
   logic [15:0] cj_next;
   logic [15:0] cj_clamped;
   logic [1:0] oc_sel;
   logic cj_en;
   logic [2:0] tc_type;

   // combinational results
   logic signed [19:0] cj_equiv, lin_val;
   logic [18:0] comp_code, lin_clamped;
   logic hot_out, cj_out, cj_hi_x, cj_lo_x, tc_hi_x, tc_lo_x;
   logic [23:0] open_len;

   function automatic logic signed [19:0] interp(input logic signed [19:0] y0,
         input logic signed [19:0] y1, input logic [14:0] frac, input int unsigned sh);
      logic signed [36:0] prod;
      prod = (y1 - y0) * $signed({1'b0, frac});
      interp = y0 + 20'(prod >>> sh);
   endfunction : interp

   assign oc_sel = {cfg0[`TCR_C0_OC_HI], cfg0[`TCR_C0_OC_LO]};
   assign cj_en = ~cfg0[`TCR_C0_CJ_OFF];
   assign tc_type = cfg1[2:0];

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         pin_meta <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
         pin_sync <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
         pin_prev <= '{cs_n: 1'b1, sclk: 1'b0, sdi: 1'b0};
         viol_meta <= 1'b0;
         viol_sync <= 1'b0;
      end else begin
         pin_meta <= '{cs_n: spi_cs_n_in, sclk: spi_sclk_in, sdi: spi_sdi_in};
         pin_sync <= pin_meta;
         pin_prev <= pin_sync;
         viol_meta <= input_range_violation_in;
         viol_sync <= viol_meta;
      end
   end

   // clock polarity is whatever sclk idles at when select falls
   assign cs_fall = pin_prev.cs_n & ~pin_sync.cs_n;
   assign lead_edge = ~pin_sync.cs_n & ~pin_prev.cs_n & (pin_prev.sclk == idle_pol)
                      & (pin_sync.sclk != idle_pol);
   assign trail_edge = ~pin_sync.cs_n & ~pin_prev.cs_n & (pin_prev.sclk != idle_pol)
                       & (pin_sync.sclk == idle_pol);
   assign rx_byte = {shift_in[6:0], pin_sync.sdi};
   assign byte_done = trail_edge & (bit_cnt == 3'h7);
   assign wr_en = byte_done & ~addr_phase & is_write;
   assign rd_load = byte_done & (addr_phase ? ~rx_byte[7] : ~is_write);
   assign rd_addr = addr_phase ? rx_byte[6:0] : addr + 7'h01;
   assign drdy_clr = rd_load & ((rd_addr >= `TCR_ADDR_LIN2 && rd_addr <= `TCR_ADDR_LIN0)
                     | (cj_en & (rd_addr == `TCR_ADDR_CJTH || rd_addr == `TCR_ADDR_CJTL)));

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         idle_pol <= 1'b0;
      end else if (cs_fall) begin
         idle_pol <= pin_sync.sclk;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         bit_cnt <= 3'h0;
         shift_in <= 8'h00;
         addr <= 7'h00;
         is_write <= 1'b0;
         addr_phase <= 1'b1;
         tx <= 8'h00;
         spi_sdo_out <= 1'b0;
         spi_sdo_oe_out <= 1'b0;
      end else if (pin_sync.cs_n) begin
         bit_cnt <= 3'h0;
         addr_phase <= 1'b1;
         spi_sdo_oe_out <= 1'b0;
      end else begin
         if (trail_edge) begin
            shift_in <= rx_byte;
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7) begin
               addr_phase <= 1'b0;
               if (addr_phase) begin
                  addr <= rx_byte[6:0];
                  is_write <= rx_byte[7];
               end else begin
                  // bursts wrap inside the 7-bit space
                  addr <= addr + 7'h01;
               end
            end
         end
         // output stays released until a full byte is ready
         if (rd_load) begin
            tx <= rd_data;
            spi_sdo_oe_out <= 1'b1;
         end else if (lead_edge && spi_sdo_oe_out) begin
            spi_sdo_out <= tx[7];
            tx <= {tx[6:0], 1'b0};
         end
      end
   end

   // [RULE6] burst snapshot at select
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         lin_shadow <= 24'h000000;
         cj_shadow <= 16'h0000;
      end else if (cs_fall) begin
         lin_shadow <= lin_word;
         cj_shadow <= cj_word;
      end
   end

   always_comb begin
      case (rd_addr)
         `TCR_ADDR_CFG0: rd_data = cfg0;
         `TCR_ADDR_CFG1: rd_data = cfg1;
         `TCR_ADDR_MASK: rd_data = mask;
         `TCR_ADDR_CJHF: rd_data = cjhf;
         `TCR_ADDR_CJLF: rd_data = cjlf;
         `TCR_ADDR_LTHFH: rd_data = lthf[15:8];
         `TCR_ADDR_LTHFL: rd_data = lthf[7:0];
         `TCR_ADDR_LTLFH: rd_data = ltlf[15:8];
         `TCR_ADDR_LTLFL: rd_data = ltlf[7:0];
         `TCR_ADDR_CJTO: rd_data = cjto;
         `TCR_ADDR_CJTH: rd_data = cj_shadow[15:8];
         `TCR_ADDR_CJTL: rd_data = cj_shadow[7:0];
         // [RULE4] result bytes, most significant first
         `TCR_ADDR_LIN2: rd_data = lin_shadow[23:16];
         `TCR_ADDR_LIN1: rd_data = lin_shadow[15:8];
         `TCR_ADDR_LIN0: rd_data = lin_shadow[7:0];
         `TCR_ADDR_FAULT: rd_data = status;
         default: rd_data = `TCR_UNMAPPED_DATA;
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cfg0 <= `TCR_RST_CFG0;
         cfg1 <= `TCR_RST_CFG1;
         mask <= `TCR_RST_MASK;
         cjhf <= `TCR_RST_CJHF;
         cjlf <= `TCR_RST_CJLF;
         lthf <= `TCR_RST_LTHF;
         ltlf <= `TCR_RST_LTLF;
         cjto <= `TCR_RST_CJTO;
         cj_word <= 16'h0000;
         oc_zeroed <= 1'b0;
         demand_req <= 1'b0;
      end else begin
         // one-shot and fault clear drop by themselves; a fresh write wins
         if (conv_complete) cfg0[`TCR_C0_ONESHOT] <= 1'b0;
         cfg0[`TCR_C0_FCLR] <= 1'b0;
         if (demand_taken) demand_req <= 1'b0;
         if (cj_load && cj_en) cj_word <= cj_next;
         if (wr_en) begin
            case (addr)
               `TCR_ADDR_CFG0: begin
                  cfg0 <= rx_byte;
                  // [RULE15] off then on asks for one test
                  if (rx_byte[`TCR_C0_OC_HI:`TCR_C0_OC_LO] == 2'h0) begin
                     oc_zeroed <= 1'b1;
                  end else if (oc_zeroed) begin
                     oc_zeroed <= 1'b0;
                     demand_req <= 1'b1;
                  end
               end
               `TCR_ADDR_CFG1: cfg1 <= rx_byte;
               `TCR_ADDR_MASK: mask <= rx_byte;
               `TCR_ADDR_CJHF: cjhf <= rx_byte;
               `TCR_ADDR_CJLF: cjlf <= rx_byte;
               `TCR_ADDR_LTHFH: lthf[15:8] <= rx_byte;
               `TCR_ADDR_LTHFL: lthf[7:0] <= rx_byte;
               `TCR_ADDR_LTLFH: ltlf[15:8] <= rx_byte;
               `TCR_ADDR_LTLFL: ltlf[7:0] <= rx_byte;
               `TCR_ADDR_CJTO: cjto <= rx_byte;
               // external sensor value only while the internal one is off
               `TCR_ADDR_CJTH: if (!cj_en) cj_word[15:8] <= rx_byte;
               `TCR_ADDR_CJTL: if (!cj_en) cj_word[7:2] <= rx_byte[7:2];
               default: ;
            endcase
         end
      end
   end

   always_comb begin
      logic [15:0] cj_u;
      logic signed [19:0] cj_base;
      logic signed [28:0] cj_prod;
      logic signed [17:0] cj_sum;
      logic [4:0] li;
      cj_u = 16'h0000;
      cj_base = 20'sh00000;
      cj_prod = 29'sh0000000;
      cj_sum = 18'sh00000;
      li = 5'h00;
      // [RULE1] interpolate in 32-degree steps from -64 degrees
      cj_u = cj_word + `TCR_CJ_BIAS;
      cj_base = interp(20'(CJ_LUT[cj_u[15:13]]), 20'(CJ_LUT[3'(cj_u[15:13] + 3'h1)]),
                       {2'h0, cj_u[12:0]}, 13);
      cj_prod = cj_base * $signed({1'b0, 8'(SENS[tc_type])});
      cj_equiv = 20'(cj_prod >>> `TCR_SENS_SHIFT);
      // [RULE2] compensated code
      comp_code = 19'(raw_code + cj_code[18:0]);
      li = {1'b0, ~comp_code[18], comp_code[17:15]};
      lin_val = interp(20'(LIN_DEG[li] * `TCR_LIN_SCALE),
                       20'(LIN_DEG[5'(li + 5'h01)] * `TCR_LIN_SCALE), comp_code[14:0], 15);
      // [RULE20] hot-junction range for the type
      hot_out = (lin_val < 20'(HOT_LO[tc_type] * `TCR_LIN_SCALE))
                | (lin_val > 20'(HOT_HI[tc_type] * `TCR_LIN_SCALE));
      // [RULE21] report the limit instead
      if (lin_val < 20'(HOT_LO[tc_type] * `TCR_LIN_SCALE)) begin
         lin_clamped = 19'(HOT_LO[tc_type] * `TCR_LIN_SCALE);
      end else if (lin_val > 20'(HOT_HI[tc_type] * `TCR_LIN_SCALE)) begin
         lin_clamped = 19'(HOT_HI[tc_type] * `TCR_LIN_SCALE);
      end else begin
         lin_clamped = lin_val[18:0];
      end
      cj_out = ($signed(cj_word) < 16'(CJ_LO[tc_type] * `TCR_CJ_SCALE))
               | ($signed(cj_word) > 16'(CJ_HI * `TCR_CJ_SCALE));
      // [RULE25] strict signed compare
      cj_hi_x = $signed(cj_word) > $signed({cjhf, 8'h00});
      cj_lo_x = $signed(cj_word) < $signed({cjlf, 8'h00});
      // [RULE9] thresholds align with result bits 23:8
      tc_hi_x = $signed(lin_clamped[18:3]) > $signed(lthf);
      tc_lo_x = $signed(lin_clamped[18:3]) < $signed(ltlf);
      // [RULE24] measured plus offset, offset lsb 1/16 degree
      cj_sum = $signed({{4{cj_meas_in[13]}}, cj_meas_in})
               + $signed({{8{cjto[7]}}, cjto, 2'h0});
      // [RULE23] clamp to -64 and just under 128 degrees
      cj_sum = {cj_sum[15:0], 2'h0};
      if (cj_sum > $signed(`TCR_CJ_MAX)) cj_sum = $signed(`TCR_CJ_MAX);
      else if (cj_sum < $signed(`TCR_CJ_MIN)) cj_sum = $signed(`TCR_CJ_MIN);
      cj_clamped = cj_sum[15:0];
   end

   // [RULE3] low two bits of the word stay zero
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         cj_next <= 16'h0000;
      end else begin
         cj_next <= {cj_clamped[15:2], 2'h0};
      end
   end

   // [RULE18] window length by code and sensing
   always_comb begin
      case ({cj_en, oc_sel})
         3'h5: open_len = 24'(OPEN_CJ_01_CYC);
         3'h6: open_len = 24'(OPEN_CJ_10_CYC);
         3'h7: open_len = 24'(OPEN_CJ_11_CYC);
         3'h1: open_len = 24'(OPEN_NOCJ_01_CYC);
         3'h2: open_len = 24'(OPEN_NOCJ_10_CYC);
         3'h3: open_len = 24'(OPEN_NOCJ_11_CYC);
         default: open_len = 24'h000001;
      endcase
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         state <= tcr_pkg::TCR_S_IDLE;
         cyc_cnt <= 24'h000000;
         conv_cnt <= 4'h0;
         test_due <= 1'b0;
         raw_code <= 19'h00000;
         cj_code <= 20'sh00000;
         lin_word <= 24'h000000;
         adc_start_out <= 1'b0;
         open_bias_out <= 1'b0;
         cj_load <= 1'b0;
         result_upd <= 1'b0;
         open_upd <= 1'b0;
         open_result <= 1'b0;
         conv_complete <= 1'b0;
         demand_taken <= 1'b0;
      end else begin
         adc_start_out <= 1'b0;
         cj_load <= 1'b0;
         result_upd <= 1'b0;
         open_upd <= 1'b0;
         conv_complete <= 1'b0;
         demand_taken <= 1'b0;
         case (state)
            tcr_pkg::TCR_S_IDLE: begin
               // [RULE11] no start while inputs are out of range
               if (!viol_sync && (cfg0[`TCR_C0_CMODE] || cfg0[`TCR_C0_ONESHOT])) begin
                  adc_start_out <= 1'b1;
                  state <= tcr_pkg::TCR_S_CONV;
               end
            end
            tcr_pkg::TCR_S_CONV: begin
               if (viol_sync) begin
                  // [RULE11] drop the conversion, retry when clear
                  state <= tcr_pkg::TCR_S_IDLE;
               end else if (adc_done_in) begin
                  raw_code <= adc_code_in;
                  // [RULE12] [RULE13] [RULE14] [RULE15] decide on a test
                  test_due <= (oc_sel != 2'h0) && (!cfg0[`TCR_C0_CMODE]
                              || conv_cnt == 4'h0 || demand_req);
                  // [RULE17] with a test due, sensing rides inside it
                  cj_load <= (oc_sel == 2'h0) || !(!cfg0[`TCR_C0_CMODE]
                             || conv_cnt == 4'h0 || demand_req);
                  state <= tcr_pkg::TCR_S_COMP;
               end
            end
            tcr_pkg::TCR_S_COMP: begin
               cj_code <= cj_equiv;
               state <= tcr_pkg::TCR_S_LIN;
            end
            tcr_pkg::TCR_S_LIN: begin
               // [RULE5] 19 bits on top, low five zero
               lin_word <= {lin_clamped, 5'h00};
               result_upd <= 1'b1;
               if (test_due) begin
                  open_bias_out <= 1'b1;
                  cyc_cnt <= open_len;
                  demand_taken <= 1'b1;
                  state <= tcr_pkg::TCR_S_OPEN;
               end else begin
                  state <= tcr_pkg::TCR_S_DONE;
               end
            end
            tcr_pkg::TCR_S_OPEN: begin
               if (cyc_cnt <= 24'h000001) begin
                  open_bias_out <= 1'b0;
                  open_result <= open_circuit_in;
                  open_upd <= 1'b1;
                  cj_load <= 1'b1;
                  state <= tcr_pkg::TCR_S_DONE;
               end else begin
                  cyc_cnt <= cyc_cnt - 24'h000001;
               end
            end
            tcr_pkg::TCR_S_DONE: begin
               conv_complete <= 1'b1;
               conv_cnt <= conv_cnt + 4'h1;
               state <= tcr_pkg::TCR_S_IDLE;
            end
            default: state <= tcr_pkg::TCR_S_IDLE;
         endcase
      end
   end

   // comparator mode follows each update, interrupt mode latches; a set beats a clear
   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         status <= '0;
      end else if (cfg0[`TCR_C0_INT_MODE]) begin
         status <= (cfg0[`TCR_C0_FCLR] ? '0 : status)
                   | {{6{result_upd}} & {cj_out, hot_out, cj_hi_x, cj_lo_x, tc_hi_x, tc_lo_x},
                      viol_sync, open_upd & open_result};
      end else begin
         if (result_upd) begin
            // [RULE20] [RULE7] [RULE8] range and threshold flags
            status.cj_range <= cj_out;
            status.tc_range <= hot_out;
            status.cj_high <= cj_hi_x;
            status.cj_low <= cj_lo_x;
            status.tc_high <= tc_hi_x;
            status.tc_low <= tc_lo_x;
         end
         // [RULE10] live input violation flag
         status.input_range_violation <= viol_sync;
         // [RULE19] [RULE16] open flag changes only when a test ends
         if (open_upd) status.open <= open_result;
      end
   end

   always_ff @(posedge clk_in or posedge reset_in) begin
      if (reset_in) begin
         fault_n_out <= 1'b1;
         data_ready_n_out <= 1'b1;
      end else begin
         // [RULE22] only bits 5:0 reach the fault pin
         fault_n_out <= ~|(status[5:0] & ~mask[5:0]);
         if (result_upd) data_ready_n_out <= 1'b0;
         else if (drdy_clr) data_ready_n_out <= 1'b1;
      end
   end
endmodule : tcr_top

// ---- verif/tcr_top_properties.sv ----
// checker: timing relations at the pins of tcr_top
// assumes bind from the bench, one clock domain
`timescale 1ns/1ps
module tcr_props (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic spi_cs_n_in,
   input wire logic spi_sdo_oe_out,
   input wire logic fault_n_out,
   input wire logic data_ready_n_out,
   input wire logic adc_start_out,
   input wire logic adc_done_in,
   input wire logic open_bias_out,
   input wire logic input_range_violation_in
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (reset_in);
   // four cycles cover the input synchroniser
   a_halt_on_violation: assert property (input_range_violation_in [*4] |-> !adc_start_out)
      else $error("start while input violated");
   a_result_ready: assert property (adc_done_in && !input_range_violation_in |->
      ##[2:6] !data_ready_n_out)
      else $error("no ready after done");
   a_start_single: assert property (adc_start_out |=> !adc_start_out [*2])
      else $error("start not a single pulse");
   a_bias_hold: assert property ($rose(open_bias_out) |-> open_bias_out [*8])
      else $error("open window too short");
   a_bias_no_conv: assert property (open_bias_out |-> !adc_start_out)
      else $error("start inside open window");
   a_done_outside_bias: assert property (adc_done_in |-> !open_bias_out)
      else $error("conversion ends in window");
   a_sdo_idle: assert property (spi_cs_n_in [*6] |-> !spi_sdo_oe_out)
      else $error("sdo driven while deselected");
   a_ready_by_read: assert property ($rose(data_ready_n_out) |-> !spi_cs_n_in)
      else $error("ready cleared outside a read");
   c_start: cover property (adc_start_out);
   c_bias: cover property ($rose(open_bias_out));
   c_fault: cover property ($fell(fault_n_out));
endmodule : tcr_props

// ---- verif/tcr_host_model.sv ----
// serial host model: mode with data latched on trailing edges
// assumes an 80 ns serial clock, clock idle low between frames
`timescale 1ns/1ps
module tcr_host_model (
   input wire logic clk_in,
   input wire logic sdo_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic sdi_out
);
   logic [7:0] rx [3];
   initial begin
      cs_n_out = 1'h1;
      sclk_out = 1'h0;
      sdi_out = 1'h0;
   end
   task automatic xfer(input logic [7:0] adr, input logic [7:0] wd, input int n);
      logic [7:0] b;
      @(negedge clk_in) cs_n_out = 1'h0;
      #80;
      for (int i = 0; i <= n; i++) begin
         b = (i == 0) ? adr : wd;
         for (int k = 7; k >= 0; k--) begin
            sclk_out = 1'h1;
            sdi_out = b[k];
            #40 sclk_out = 1'h0;
            // sampled late: the bit stands until the next leading edge
            #40 if (i > 0) rx[i - 1][k] = sdo_in;
         end
      end
      #80 cs_n_out = 1'h1;
      sdi_out = ~sdi_out;
      #200;
   endtask : xfer
endmodule : tcr_host_model

// ---- verif/tcr_top_tb_top.sv ----
// testbench: registers, thresholds, input violation, open test
// assumes host model and checker files compiled before this one
`timescale 1ns/1ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; \
   $display("FAIL %s exp %h got %h", n, e, s); end end
module tcr_top_tb_top;
   logic clk_in = 0, reset_in = 1, adc_done_in = 0, open_circuit_in = 0;
   logic input_range_violation_in = 0;
   logic [18:0] adc_code_in = 19'h00100;
   logic [13:0] cj_meas_in = 14'h1000;
   logic cs_n, sclk, sdi, sdo, sdo_oe, sdo_w, fault_n, rdy_n, start, bias;
   int bad_count = 0, samples_checked = 0, cyc = 0;
   logic [7:0] rv [12] = '{8'h00, 8'h03, 8'hFF, 8'h7F, 8'hC0, 8'h7F, 8'hFF, 8'h80,
      8'h00, 8'h00, 8'h00, 8'h00};
   always #5 clk_in = ~clk_in;
   assign sdo_w = sdo_oe ? sdo : 1'bz;
   // short open windows keep the run brief
   tcr_top #(.OPEN_CJ_01_CYC(40), .OPEN_NOCJ_01_CYC(40)) u_tcr_top (.clk_in, .reset_in,
      .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_sdi_in(sdi), .spi_sdo_out(sdo),
      .spi_sdo_oe_out(sdo_oe), .fault_n_out(fault_n), .data_ready_n_out(rdy_n),
      .adc_start_out(start), .adc_done_in, .adc_code_in, .cj_meas_in,
      .open_bias_out(bias), .open_circuit_in, .input_range_violation_in);
   tcr_host_model u_tcr_host_model (.clk_in, .sdo_in(sdo_w), .cs_n_out(cs_n),
      .sclk_out(sclk), .sdi_out(sdi));
   always @(negedge clk_in) if (start) begin
      repeat (20) @(negedge clk_in);
      adc_done_in = 1'h1;
      @(negedge clk_in) adc_done_in = 1'h0;
   end
   always @(posedge clk_in) if (++cyc == 40000) begin
      bad_count++;
      conclude();
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      u_tcr_host_model.xfer(a | 8'h80, d, 1);
   endtask : wr
   task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      u_tcr_host_model.xfer(a, 8'h00, 1);
      `CHK($sformatf("reg %h", a), e, u_tcr_host_model.rx[0] & m)
   endtask : rdm
   task automatic waitrdy;
      for (int i = 0; i < 3000 && rdy_n !== 1'h0; i++) @(negedge clk_in);
      `CHK("ready", 1'h0, rdy_n)
   endtask : waitrdy
   task automatic conclude;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   initial begin
      repeat (4) @(negedge clk_in);
      reset_in = 0;
      repeat (4) @(negedge clk_in);
      for (int i = 0; i < 12; i++) rdm(8'(i), 8'hFF, rv[i]);
      rdm(8'h10, 8'hFF, 8'hFF);
      wr(8'h0F, 8'h55);
      rdm(8'h0F, 8'hFF, 8'h00);
      $display("test registers done");
      wr(8'h00, 8'h08);
      wr(8'h0A, 8'h40);
      wr(8'h03, 8'h30);
      wr(8'h05, 8'h80);
      wr(8'h06, 8'h00);
      wr(8'h07, 8'h7F);
      wr(8'h08, 8'hFF);
      wr(8'h02, 8'hD3);
      wr(8'h00, 8'h48);
      waitrdy();
      rdm(8'h0F, 8'h3F, 8'h2C);
      `CHK("fault", 1'h0, fault_n)
      u_tcr_host_model.xfer(8'h0C, 8'h00, 3);
      `CHK("result low bits", 5'h00, u_tcr_host_model.rx[2][4:0])
      `CHK("ready after read", 1'h1, rdy_n)
      rdm(8'h0A, 8'hFF, 8'h40);
      $display("test thresholds done");
      wr(8'h02, 8'hFD);
      input_range_violation_in = 1;
      wr(8'h00, 8'h48);
      repeat (300) @(negedge clk_in);
      rdm(8'h0F, 8'h02, 8'h02);
      `CHK("fault", 1'h0, fault_n)
      `CHK("held off", 1'h1, rdy_n)
      input_range_violation_in = 0;
      waitrdy();
      rdm(8'h0E, 8'h1F, 8'h00);
      $display("test violation done");
      wr(8'h02, 8'hFE);
      open_circuit_in = 1;
      wr(8'h00, 8'h58);
      waitrdy();
      `CHK("bias", 1'h1, bias)
      repeat (100) @(negedge clk_in);
      rdm(8'h0F, 8'h01, 8'h01);
      `CHK("fault", 1'h0, fault_n)
      $display("test open circuit done");
      conclude();
   end
endmodule : tcr_top_tb_top
bind tcr_top tcr_props u_tcr_props (.clk_in, .reset_in, .spi_cs_n_in, .spi_sdo_oe_out,
   .fault_n_out, .data_ready_n_out, .adc_start_out, .adc_done_in, .open_bias_out,
   .input_range_violation_in);
